// ==== rtl/dcdc_converter_control_regs.sv ====
// Converter control register bank: three SFRs, decoded fields driven
// to the power stage and ADC, plus converter clock generation.
// Assumes single-cycle SFR read/write strobes synchronous to core_clk.
`timescale 1ns/1ns
module dcdc_converter_control_regs (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic [7:0] sfr_wdata,
	input wire logic sfr_rd,
	output logic [7:0] sfr_rdata,
	input wire logic osc_tick,
	input wire logic switch_active,
	input wire logic sleep_mode,
	output logic conv_tick,
	output logic conv_clk_inverted,
	output logic conv_clk_from_sysclk,
	output logic [1:0] min_pulse_width,
	output logic [2:0] min_pulse_cycles,
	output logic switch_size_select,
	output logic [2:0] output_voltage_select,
	output logic low_power_enable,
	output logic peak_current_threshold,
	output logic passive_diode_enable,
	output logic bypass_ctrl_enable,
	output logic converter_enable,
	output logic output_to_battery,
	output logic output_floating,
	output logic adc_sync_enable,
	output logic adc_track_allow,
	output logic sar_clock_tick,
	output logic sar_clock_invert
);
	import dcdc_ctrl_pkg::*;

	typedef struct packed {
		logic [7:0] ctl;
		logic [7:0] cfg;
		logic [7:0] mode;
		logic [7:0] rdata;
		logic [2:0] pw_cyc;
		logic diode;
		logic conv_en;
		logic to_batt;
		logic floating;
		logic track;
		logic sar_tick;
		logic sar_inv;
	} bank_state_t;

	bank_state_t cur_ff;
	bank_state_t nxt_cur;
	logic gen_tick;
	logic sync_on;

	converter_clock_gen converter_clock_gen_inst (
		.core_clk(core_clk),
		.reset(reset),
		.use_sysclk(cur_ff.cfg[CFG_CLKSRC]),
		.div_code(cur_ff.cfg[CFG_DIV_LO +: 2]),
		.invert(cur_ff.cfg[CFG_SYSINV]),
		.osc_tick(osc_tick),
		.conv_tick(gen_tick),
		.conv_inverted(conv_clk_inverted),
		.conv_from_sysclk(conv_clk_from_sysclk)
	);

	always_comb begin
		nxt_cur = cur_ff;
		sync_on = cur_ff.ctl[CTL_SYNC];
		// Register writes; bit 4 of control is stored as written
		if (sfr_wr) begin
			case (sfr_addr)
				ADDR_CONTROL: nxt_cur.ctl = sfr_wdata;
				ADDR_CLOCK_CONFIG: nxt_cur.cfg = sfr_wdata;
				ADDR_MODE: nxt_cur.mode = sfr_wdata & MODE_MASK;
				default: nxt_cur.ctl = cur_ff.ctl;
			endcase
		end
		if (sfr_rd) begin
			case (sfr_addr)
				ADDR_CONTROL: nxt_cur.rdata = cur_ff.ctl;
				ADDR_CLOCK_CONFIG: nxt_cur.rdata = cur_ff.cfg;
				ADDR_MODE: nxt_cur.rdata = cur_ff.mode;
				default: nxt_cur.rdata = 8'h00;
			endcase
		end
		nxt_cur.pw_cyc = min_pw_cycles(cur_ff.ctl[CTL_PULSE_LO +: 2]);
		nxt_cur.diode = cur_ff.mode[MODE_PASSIVE];
		// Sleep turns the converter off and picks the output connection
		nxt_cur.conv_en = !sleep_mode;
		nxt_cur.to_batt = sleep_mode && !cur_ff.cfg[CFG_SLEEPFLOAT];
		nxt_cur.floating = sleep_mode && cur_ff.cfg[CFG_SLEEPFLOAT];
		// Tracking held off while the switch conducts, only under sync
		nxt_cur.track = !sync_on || !switch_active;
		nxt_cur.sar_tick = sync_on && gen_tick;
		nxt_cur.sar_inv = sync_on && !cur_ff.cfg[CFG_SARINV];
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			cur_ff <= '0;
			cur_ff.ctl <= RST_CONTROL;
			cur_ff.cfg <= RST_CLOCK_CONFIG;
			cur_ff.mode <= RST_MODE;
			cur_ff.conv_en <= 1'b1;
			cur_ff.track <= 1'b1;
		end else begin
			cur_ff <= nxt_cur;
		end
	end

	assign sfr_rdata = cur_ff.rdata;
	assign conv_tick = gen_tick;
	assign min_pulse_width = cur_ff.ctl[CTL_PULSE_LO +: 2];
	assign min_pulse_cycles = cur_ff.pw_cyc;
	assign switch_size_select = cur_ff.ctl[CTL_SWSIZE];
	assign output_voltage_select = cur_ff.ctl[CTL_VOLT_LO +: 3];
	assign low_power_enable = cur_ff.cfg[CFG_LOWPOWER];
	assign peak_current_threshold = cur_ff.cfg[CFG_PEAK_LIM];
	assign passive_diode_enable = cur_ff.diode;
	assign bypass_ctrl_enable = !cur_ff.diode;
	assign converter_enable = cur_ff.conv_en;
	assign output_to_battery = cur_ff.to_batt;
	assign output_floating = cur_ff.floating;
	assign adc_sync_enable = cur_ff.ctl[CTL_SYNC];
	assign adc_track_allow = cur_ff.track;
	assign sar_clock_tick = cur_ff.sar_tick;
	assign sar_clock_invert = cur_ff.sar_inv;

	// Address decode shared by the checker sequences
	function automatic logic is_mapped(input logic [7:0] addr);
		is_mapped = (addr == ADDR_CONTROL) || (addr == ADDR_CLOCK_CONFIG)
			|| (addr == ADDR_MODE);
	endfunction : is_mapped

	sequence s_ctl_write;
		sfr_wr && sfr_addr == ADDR_CONTROL;
	endsequence
	sequence s_cfg_write;
		sfr_wr && sfr_addr == ADDR_CLOCK_CONFIG;
	endsequence
	sequence s_mode_write;
		sfr_wr && sfr_addr == ADDR_MODE;
	endsequence
	sequence s_mode_read;
		sfr_rd && sfr_addr == ADDR_MODE;
	endsequence
	sequence s_other_write;
		sfr_wr && !is_mapped(sfr_addr);
	endsequence
	sequence s_other_read;
		sfr_rd && !is_mapped(sfr_addr);
	endsequence
	sequence s_quiet_cycle;
		!sfr_wr;
	endsequence

	a_pulse_width: assert property (
		@(posedge core_clk) disable iff (reset)
		s_ctl_write ##2 s_quiet_cycle |-> min_pulse_cycles ==
		min_pw_cycles($past(sfr_wdata[CTL_PULSE_LO +: 2], 2)))
		else $error("minimum pulse cycles wrong");
	a_switch_size: assert property (
		@(posedge core_clk) disable iff (reset)
		s_ctl_write |=> switch_size_select == $past(sfr_wdata[CTL_SWSIZE]))
		else $error("switch size not from bit 5");
	a_voltage_sel: assert property (
		@(posedge core_clk) disable iff (reset)
		s_ctl_write |=> output_voltage_select ==
		$past(sfr_wdata[CTL_VOLT_LO +: 3]))
		else $error("voltage select not from write");
	a_low_power: assert property (
		@(posedge core_clk) disable iff (reset)
		s_cfg_write |=> low_power_enable == $past(sfr_wdata[CFG_LOWPOWER]))
		else $error("low power bit not applied");
	a_peak_limit: assert property (
		@(posedge core_clk) disable iff (reset)
		s_cfg_write |=> peak_current_threshold ==
		$past(sfr_wdata[CFG_PEAK_LIM]))
		else $error("current threshold not applied");
	a_passive_diode: assert property (
		@(posedge core_clk) disable iff (reset)
		s_mode_write ##1 s_quiet_cycle
		|=> bypass_ctrl_enable == !$past(sfr_wdata[MODE_PASSIVE], 2))
		else $error("bypass control not off in passive mode");
	a_mode_upper: assert property (
		@(posedge core_clk) disable iff (reset)
		s_mode_read |=> sfr_rdata[7:1] == 7'h00)
		else $error("mode upper bits not zero");
	a_other_read: assert property (
		@(posedge core_clk) disable iff (reset)
		s_other_read |=> sfr_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_other_write: assert property (
		@(posedge core_clk) disable iff (reset)
		s_other_write |=> $stable(output_voltage_select) &&
		$stable(switch_size_select) && $stable(low_power_enable))
		else $error("unmapped write changed a field");
	a_rdata_hold: assert property (
		@(posedge core_clk) disable iff (reset)
		!sfr_rd |=> $stable(sfr_rdata))
		else $error("read data moved without a read");
	a_sleep_conn: assert property (
		@(posedge core_clk) disable iff (reset)
		sleep_mode |=> !converter_enable && (output_to_battery ==
		!cur_ff.cfg[CFG_SLEEPFLOAT] || $past(sfr_wr)))
		else $error("sleep output connection wrong");
	a_awake_enable: assert property (
		@(posedge core_clk) disable iff (reset)
		!sleep_mode |=> converter_enable)
		else $error("converter off while awake");
	a_awake_conn: assert property (
		@(posedge core_clk) disable iff (reset)
		!sleep_mode |=> !output_to_battery && !output_floating)
		else $error("sleep connection while awake");
	a_sync_track: assert property (
		@(posedge core_clk) disable iff (reset)
		(adc_sync_enable && switch_active && !sfr_wr) |=> !adc_track_allow)
		else $error("tracking allowed while switching");
	a_track_free: assert property (
		@(posedge core_clk) disable iff (reset)
		!adc_sync_enable |=> adc_track_allow)
		else $error("tracking held without sync");
	a_sar_follow: assert property (
		@(posedge core_clk) disable iff (reset)
		sar_clock_tick |-> $past(conv_tick) && $past(adc_sync_enable))
		else $error("SAR tick without converter tick");
	a_sar_invert: assert property (
		@(posedge core_clk) disable iff (reset)
		!adc_sync_enable && !$past(adc_sync_enable) |-> !sar_clock_invert
		&& !sar_clock_tick)
		else $error("SAR clock active without sync");
	a_src_osc: assert property (
		@(posedge core_clk) disable iff (reset)
		(!conv_clk_from_sysclk && !osc_tick) |=> !conv_tick)
		else $error("tick without oscillator pulse");
	a_osc_follow: assert property (
		@(posedge core_clk) disable iff (reset)
		(!conv_clk_from_sysclk && osc_tick) |=> conv_tick)
		else $error("oscillator pulse gave no tick");
endmodule : dcdc_converter_control_regs

// ==== rtl/dcdc_ctrl_pkg.sv ====
// Package: register map, field layout, reset values and timing
// constants for the step-up converter control block.
// Assumes an 8-bit special-function-register bus clocked by core_clk.
package dcdc_ctrl_pkg;
	localparam logic [7:0] ADDR_MODE = 8'h94;
	localparam logic [7:0] ADDR_CLOCK_CONFIG = 8'h96;
	localparam logic [7:0] ADDR_CONTROL = 8'h97;
	localparam logic [7:0] RST_MODE = 8'h00;
	localparam logic [7:0] RST_CLOCK_CONFIG = 8'h00;
	localparam logic [7:0] RST_CONTROL = 8'h21;
	localparam logic [7:0] MODE_MASK = 8'h01;
	// Control register fields
	localparam int CTL_PULSE_LO = 6;
	localparam int CTL_SWSIZE = 5;
	localparam int CTL_SYNC = 3;
	localparam int CTL_VOLT_LO = 0;
	// Clock config and mode fields
	localparam int CFG_LOWPOWER = 7;
	localparam int CFG_DIV_LO = 5;
	localparam int CFG_SARINV = 4;
	localparam int CFG_SYSINV = 3;
	localparam int CFG_PEAK_LIM = 2;
	localparam int CFG_SLEEPFLOAT = 1;
	localparam int CFG_CLKSRC = 0;
	localparam int MODE_PASSIVE = 0;
	// Timing
	localparam int CLK_PERIOD_NS = 20;
	localparam int PULSE_01_NS = 20;
	localparam int PULSE_10_NS = 40;
	localparam int PULSE_11_NS = 80;
	localparam logic [2:0] PULSE_01_CYC =
		3'((PULSE_01_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [2:0] PULSE_10_CYC =
		3'((PULSE_10_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [2:0] PULSE_11_CYC =
		3'((PULSE_11_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [1:0] DIV_BY1 = 2'h0;
	localparam logic [1:0] DIV_BY2 = 2'h1;
	localparam logic [1:0] DIV_BY2B = 2'h2;
	localparam logic [1:0] DIV_BY8 = 2'h3;

	// Minimum pulse code to core_clk cycles, zero means no minimum
	function automatic logic [2:0] min_pw_cycles(input logic [1:0] code);
		case (code)
			2'h1: min_pw_cycles = PULSE_01_CYC;
			2'h2: min_pw_cycles = PULSE_10_CYC;
			2'h3: min_pw_cycles = PULSE_11_CYC;
			default: min_pw_cycles = 3'h0;
		endcase
	endfunction : min_pw_cycles

	// Divider code to terminal count of the system clock counter
	function automatic logic [2:0] div_last(input logic [1:0] code);
		case (code)
			DIV_BY2: div_last = 3'h1;
			DIV_BY2B: div_last = 3'h1;
			DIV_BY8: div_last = 3'h7;
			default: div_last = 3'h0;
		endcase
	endfunction : div_last
endpackage : dcdc_ctrl_pkg

// ==== rtl/converter_clock_gen.sv ====
// Converter clock selection, division and inversion.
// Assumes osc_tick is a one-cycle pulse per local oscillator period,
// synchronous to core_clk, which is also the system clock.
`timescale 1ns/1ns
module converter_clock_gen (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic use_sysclk,
	input wire logic [1:0] div_code,
	input wire logic invert,
	input wire logic osc_tick,
	output logic conv_tick,
	output logic conv_inverted,
	output logic conv_from_sysclk
);
	import dcdc_ctrl_pkg::*;

	typedef struct packed {
		logic [2:0] cnt;
		logic sel;
		logic [1:0] div;
		logic inv;
		logic tick;
	} gen_state_t;

	gen_state_t cur_ff;
	gen_state_t nxt_cur;
	logic boundary;

	always_comb begin
		nxt_cur = cur_ff;
		// Cycle end of whichever source is active
		boundary = cur_ff.sel ? (cur_ff.cnt == div_last(cur_ff.div))
			: osc_tick;
		nxt_cur.tick = boundary;
		nxt_cur.cnt = cur_ff.cnt + 3'h1;
		if (boundary) begin
			// Settings adopted only at a period end, so no runt pulse
			nxt_cur.cnt = 3'h0;
			nxt_cur.sel = use_sysclk;
			nxt_cur.div = div_code;
			nxt_cur.inv = invert;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			cur_ff <= '0;
		end else begin
			cur_ff <= nxt_cur;
		end
	end

	assign conv_tick = cur_ff.tick;
	assign conv_inverted = cur_ff.inv;
	assign conv_from_sysclk = cur_ff.sel;

	a_div8_spacing: assert property (
		@(posedge core_clk) disable iff (reset)
		(conv_tick && cur_ff.sel && cur_ff.div == DIV_BY8)
		|-> ##1 !conv_tick [*7])
		else $error("divide by 8 tick spacing wrong");
	a_glitch_free: assert property (
		@(posedge core_clk) disable iff (reset)
		($changed(cur_ff.inv) || $changed(cur_ff.sel)) |-> conv_tick)
		else $error("clock setting changed mid period");
endmodule : converter_clock_gen

// ==== testbench/power_stage_model.sv ====
// Far-side model: local oscillator ticks, switch activity, sleep state.
// Assumes core_clk is also the system clock; outputs move 2 ns after it.
`timescale 1ns/1ns
module power_stage_model #(
	parameter int OSC_PERIOD = 4
) (
	input wire logic core_clk,
	input wire logic sleep_req,
	output logic osc_tick,
	output logic switch_active,
	output logic sleep_mode
);
	int cnt = 0;
	initial begin
		osc_tick = 1'b0;
		switch_active = 1'b0;
		sleep_mode = 1'b0;
	end
	// Short oscillator period keeps the run brief
	always @(posedge core_clk) begin
		#2;
		cnt = (cnt + 1) % OSC_PERIOD;
		osc_tick = (cnt == 0);
		switch_active = (cnt == 1) && !sleep_mode;
		sleep_mode = sleep_req;
	end
endmodule : power_stage_model

// ==== testbench/dcdc_converter_control_regs_tb.sv ====
// Self-checking bench for the converter control register bank.
// Assumes the design package is compiled first; inputs move 2 ns late.
`timescale 1ns/1ns
module dcdc_converter_control_regs_tb;
	import dcdc_ctrl_pkg::*;
	typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] e;} row_t;
	logic core_clk = 1'b0;
	logic reset = 1'b1;
	logic [7:0] sfr_addr = 8'h00;
	logic [7:0] sfr_wdata = 8'h00;
	logic sfr_wr = 1'b0;
	logic sfr_rd = 1'b0;
	logic sleep_req = 1'b0;
	logic [7:0] sfr_rdata, rd_val, a, d;
	logic osc_tick, switch_active, sleep_mode, conv_tick, conv_clk_inverted;
	logic conv_clk_from_sysclk, switch_size_select, low_power_enable, p;
	logic peak_current_threshold, passive_diode_enable, bypass_ctrl_enable;
	logic converter_enable, output_to_battery, output_floating;
	logic adc_sync_enable, adc_track_allow, sar_clock_tick, sar_clock_invert;
	logic [1:0] min_pulse_width;
	logic [2:0] min_pulse_cycles, output_voltage_select;
	int err_count = 0;
	int checks_done = 0;
	int cycles = 0;
	int n;
	// Control rows keep bit 4 at zero
	row_t rows [8] = '{'{8'h97, 8'hC8, 8'hC8}, '{8'h97, 8'h67, 8'h67},
		'{8'h97, 8'h83, 8'h83}, '{8'h96, 8'h84, 8'h84},
		'{8'h96, 8'h7A, 8'h7A}, '{8'h94, 8'hFF, 8'h01},
		'{8'h94, 8'h00, 8'h00}, '{8'h95, 8'hAA, 8'h00}};
	logic [7:0] pw_exp [4] = '{8'h00, 8'h01, 8'h02, 8'h04};
	logic [7:0] div_exp [4] = '{8'h20, 8'h10, 8'h10, 8'h04};
	logic [7:0] rst_a [3] = '{8'h97, 8'h96, 8'h94};
	logic [7:0] rst_e [3] = '{8'h21, 8'h00, 8'h00};
	wire [7:0] ctl_obs = {1'b0, min_pulse_width, switch_size_select,
		adc_sync_enable, output_voltage_select};
	wire [7:0] cfg_obs = {6'h00, low_power_enable, peak_current_threshold};
	wire [7:0] mode_obs = {6'h00, passive_diode_enable, bypass_ctrl_enable};
	wire [7:0] sleep_obs = {5'h00, converter_enable, output_to_battery,
		output_floating};
	wire [7:0] clk_obs = {6'h00, conv_clk_inverted, conv_clk_from_sysclk};

	dcdc_converter_control_regs dcdc_converter_control_regs_inst (
		.core_clk, .reset, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rd,
		.sfr_rdata, .osc_tick, .switch_active, .sleep_mode, .conv_tick,
		.conv_clk_inverted, .conv_clk_from_sysclk, .min_pulse_width,
		.min_pulse_cycles, .switch_size_select, .output_voltage_select,
		.low_power_enable, .peak_current_threshold, .passive_diode_enable,
		.bypass_ctrl_enable, .converter_enable, .output_to_battery,
		.output_floating, .adc_sync_enable, .adc_track_allow,
		.sar_clock_tick, .sar_clock_invert);
	power_stage_model #(.OSC_PERIOD(4)) power_stage_model_inst (
		.core_clk, .sleep_req, .osc_tick, .switch_active, .sleep_mode);

	always #10 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 6000) begin
			err_count++;
			stop_test();
		end
	end

	task automatic chk(input string nm, input logic [7:0] e,
		input logic [7:0] g);
		checks_done++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic wait_cyc(input int c);
		repeat (c) @(posedge core_clk);
		#1;
	endtask : wait_cyc
	task automatic wr(input logic [7:0] wa, input logic [7:0] wd);
		@(posedge core_clk);
		#2;
		sfr_addr = wa;
		sfr_wdata = wd;
		sfr_wr = 1'b1;
		@(posedge core_clk);
		#2;
		sfr_wr = 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] ra);
		@(posedge core_clk);
		#2;
		sfr_addr = ra;
		sfr_rd = 1'b1;
		@(posedge core_clk);
		#2;
		sfr_rd = 1'b0;
		rd_val = sfr_rdata;
	endtask : rd
	task automatic count_ticks();
		n = 0;
		repeat (32) begin
			@(posedge core_clk);
			#1;
			if (conv_tick === 1'b1) n++;
		end
	endtask : count_ticks
	task automatic reset_check();
		@(posedge core_clk);
		#2;
		reset = 1'b1;
		repeat (12) @(posedge core_clk);
		#2;
		reset = 1'b0;
		for (int i = 0; i < 3; i++) begin
			rd(rst_a[i]);
			chk("reset value", rst_e[i], rd_val);
		end
	endtask : reset_check
	task automatic stop_test();
		$display("Checks %0d, errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : stop_test

	initial begin
		reset_check();
		for (int i = 0; i < 8; i++) begin
			a = rows[i].a;
			d = rows[i].d;
			wr(a, d);
			wait_cyc(2);
			if (a == 8'h97) chk("ctl", {1'b0, d[7:5], d[3:0]}, ctl_obs);
			if (a == 8'h96) chk("cfg", {6'h00, d[7], d[2]}, cfg_obs);
			if (a == 8'h94) chk("mode", {6'h00, d[0], ~d[0]}, mode_obs);
			rd(a);
			chk("readback", rows[i].e, rd_val);
		end
		for (int c = 0; c < 4; c++) begin
			wr(8'h97, {c[1:0], 6'h21});
			wait_cyc(3);
			chk("min pulse", pw_exp[c], {5'h00, min_pulse_cycles});
		end
		// Code 11 is the slowest converter clock the core clock allows
		for (int c = 0; c < 4; c++) begin
			wr(8'h96, {1'b0, c[1:0], 5'h01});
			wait_cyc(20);
			count_ticks();
			chk("div ticks", div_exp[c], n[7:0]);
		end
		wr(8'h96, 8'h60);
		wait_cyc(20);
		count_ticks();
		chk("osc ticks", 8'h08, n[7:0]);
		wr(8'h96, 8'h09);
		wait_cyc(20);
		chk("clk inv", 8'h03, clk_obs);
		wr(8'h97, 8'h28);
		wr(8'h96, 8'h01);
		wait_cyc(3);
		chk("sar inv", 8'h01, {7'h00, sar_clock_invert});
		chk("sar tick", 8'h01, {7'h00, sar_clock_tick});
		for (int k = 0; k < 8; k++) begin
			#2;
			p = switch_active;
			wait_cyc(1);
			chk("track", {7'h00, ~p}, {7'h00, adc_track_allow});
		end
		wr(8'h96, 8'h11);
		wait_cyc(3);
		chk("sar inv", 8'h00, {7'h00, sar_clock_invert});
		wr(8'h97, 8'h21);
		wr(8'h96, 8'h01);
		wait_cyc(3);
		chk("sar ignored", 8'h00, {7'h00, sar_clock_invert});
		chk("sar tick off", 8'h00, {7'h00, sar_clock_tick});
		wr(8'h96, 8'h00);
		sleep_req = 1'b1;
		wait_cyc(4);
		chk("sleep", 8'h02, sleep_obs);
		wr(8'h96, 8'h02);
		wait_cyc(3);
		chk("sleep float", 8'h01, {7'h00, output_floating});
		#1;
		sleep_req = 1'b0;
		wait_cyc(4);
		chk("awake", 8'h01, {7'h00, converter_enable});
		reset_check();
		stop_test();
	end
endmodule : dcdc_converter_control_regs_tb
